// file: sia_top.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE1] Enabled top status bits merge into one output
// [RULE2] Seven top-level sources feed the controller
// [RULE3] Timer, soft, ready live in top registers
// [RULE4] Fabric, PHY, pin bits mirror lower pending
// [RULE5] Mirrored bit stays until source cleared
// [RULE6] Software reads sub pending to find event
// [RULE7] Output enable bit gates the pin
// [RULE8] Polarity and open-drain buffer selectable
// [RULE9] De-assert timer enforces minimum inactive gap
// [RULE10] Zero interval disables the timer
// [RULE11] Interval starts on any de-assertion
// [RULE12] Fabric bit reflects global fabric pending
// [RULE13] Buffer manager two, engine one, MACs none
// [RULE14] Fabric path needs sub, global, top masks
// [RULE15] Two identical PHYs, each own top bit
// [RULE16] Seven PHY events per PHY
// [RULE17] PHY flags report cause, write-one clears
// [RULE18] PHY path needs mask, top enable, output enable
// [RULE19] Energy present bit 7 raises interrupt
// [RULE20] General power-down only by software
// [RULE21] External port mode forces first PHY down
// [RULE22] Six pins each individually enabled
// [RULE23] Timer wrap sets status, write-one clears
// [RULE24] Soft enable sets soft status
// [RULE25] Ready set after reset, write-one clears
// [RULE26] Level output: enabled status, enable, no gap
// [RULE27] Interval counts in fixed clock-derived units
//////////////////////////////////////////////////////////////////////////////
module sia_top #(
   parameter int INTV_W   = sia_pkg::INTV_BITS,
   parameter int UNIT_CYC = sia_pkg::UNIT_CYCLES
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // Register port
   input  wire sia_pkg::sia_bus_t    bus,
   output logic [15:0]               rdata,
   // Event inputs from sub-modules, same clock, one-cycle pulses
   input  wire sia_pkg::sia_events_t events,
   // Port 1 mode: 2'b11 internal PHY, others external
   input  wire logic [1:0]           port_mode,
   // PHY power control
   output logic [1:0]                phy_powerdown,
   // Interrupt pin
   output logic                      irq_out,
   output logic                      irq_oe_n
);

   logic [sia_pkg::TOP_BITS-1:0]  top_enable;
   logic [15:0]                   irq_cfg;
   logic [2:0]                    fab_mask;
   logic [1:0]                    bm_pend, bm_mask;
   logic                          eng_pend, eng_mask;
   logic [sia_pkg::PHY_BITS-1:0]  phy_flags [2];
   logic [sia_pkg::PHY_BITS-1:0]  phy_mask  [2];
   logic [sia_pkg::PIN_COUNT-1:0] pin_pend, pin_en;
   logic                          timer_sts, soft_sts, ready_sts;
   logic [1:0]                    pd_req;
   logic [INTV_W-1:0]             gap_cnt;
   logic [15:0]                   unit_cnt;
   logic                          irq_active;
   logic                          first_cycle;

   logic        wr_cycle;
   logic [15:0] wd;
   logic [2:0]  fab_pend;
   logic [sia_pkg::TOP_BITS-1:0] top_status;
   logic        any_enabled;
   logic        next_irq_active;
   logic [INTV_W-1:0] intv;

   assign wr_cycle = bus.wr;
   assign wd       = bus.wdata;
   assign intv     = irq_cfg[sia_pkg::CFG_INTV_LSB +: INTV_W];

   //////////////////////////////////////////////////////////////////////////
   // Fabric tiers; MAC tier has no live sources
   assign fab_pend[sia_pkg::FAB_BM]  = |(bm_pend & bm_mask);           // see [RULE13]
   assign fab_pend[sia_pkg::FAB_ENG] = eng_pend & eng_mask;            // see [RULE13]
   assign fab_pend[sia_pkg::FAB_MAC] = 1'b0;                           // see [RULE13]

   // Top status: mirrors of lower tiers plus direct bits
   always_comb begin
      top_status                      = '0;
      top_status[sia_pkg::BIT_FABRIC] = |(fab_pend & fab_mask);          // see [RULE12] see [RULE14]
      top_status[sia_pkg::BIT_PHY1]   = |(phy_flags[0] & phy_mask[0]);   // see [RULE15] see [RULE18]
      top_status[sia_pkg::BIT_PHY2]   = |(phy_flags[1] & phy_mask[1]);   // see [RULE15] see [RULE19]
      top_status[sia_pkg::BIT_PIN]    = |(pin_pend & pin_en);            // see [RULE22] see [RULE4]
      top_status[sia_pkg::BIT_TIMER]  = timer_sts;                       // see [RULE3]
      top_status[sia_pkg::BIT_SOFT]   = soft_sts;
      top_status[sia_pkg::BIT_READY]  = ready_sts;
   end

   assign any_enabled = |(top_status & top_enable);                      // see [RULE1] see [RULE2]

   //////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         top_enable <= sia_pkg::RST_ENABLE;
         irq_cfg    <= sia_pkg::RST_CFG;
         fab_mask   <= '0;
         bm_mask    <= '0;
         eng_mask   <= 1'b0;
         pin_en     <= '0;
         pd_req     <= '0;
      end else if (wr_cycle) begin
         unique case (bus.addr)
            sia_pkg::ADDR_ENABLE:    top_enable <= wd[sia_pkg::TOP_BITS-1:0];
            sia_pkg::ADDR_IRQ_CFG:   irq_cfg    <= wd;
            sia_pkg::ADDR_FAB_MASK:  fab_mask   <= wd[2:0];
            sia_pkg::ADDR_BM_MASK:   bm_mask    <= wd[1:0];
            sia_pkg::ADDR_ENG_MASK:  eng_mask   <= wd[0];
            sia_pkg::ADDR_PIN_EVENT: pin_en     <= wd[8 +: sia_pkg::PIN_COUNT];
            sia_pkg::ADDR_STATUS:    pd_req     <= wd[9:8];  // see [RULE20]
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Sticky pending bits: set wins over write-one clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bm_pend  <= '0;
         eng_pend <= 1'b0;
         pin_pend <= '0;
      end else begin
         bm_pend  <= events.bm | (bm_pend &
                     ~((wr_cycle && bus.addr == sia_pkg::ADDR_BM_PEND) ? wd[1:0] : 2'h0));
         eng_pend <= events.eng | (eng_pend &
                     ~(wr_cycle && bus.addr == sia_pkg::ADDR_ENG_PEND && wd[0]));
         pin_pend <= events.pin | (pin_pend &
                     ~((wr_cycle && bus.addr == sia_pkg::ADDR_PIN_EVENT) ?
                       wd[sia_pkg::PIN_COUNT-1:0] : 6'h00));               // see [RULE5]
      end
   end

   // Per-PHY source flags and masks
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_phy
         localparam logic [3:0] FLAG_ADDR = g ? sia_pkg::ADDR_PHY2_FLAGS : sia_pkg::ADDR_PHY1_FLAGS;
         localparam logic [3:0] MASK_ADDR = g ? sia_pkg::ADDR_PHY2_MASK  : sia_pkg::ADDR_PHY1_MASK;
         logic [sia_pkg::PHY_BITS-1:0] ev;
         assign ev = (g ? events.phy2 : events.phy1) & sia_pkg::PHY_VALID;  // see [RULE16]
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               phy_flags[g] <= '0;
               phy_mask[g]  <= '0;
            end else begin
               phy_flags[g] <= ev | (phy_flags[g] &
                               ~((wr_cycle && bus.addr == FLAG_ADDR) ?
                                 wd[sia_pkg::PHY_BITS-1:0] : 8'h00));   // see [RULE17]
               if (wr_cycle && bus.addr == MASK_ADDR)
                  phy_mask[g] <= wd[sia_pkg::PHY_BITS-1:0] & sia_pkg::PHY_VALID;
            end
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   // Direct top-level bits
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_sts   <= 1'b0;
         soft_sts    <= 1'b0;
         ready_sts   <= 1'b0;
         first_cycle <= 1'b1;
      end else begin
         first_cycle <= 1'b0;
         timer_sts   <= events.timer_wrap | (timer_sts &
                        ~(wr_cycle && bus.addr == sia_pkg::ADDR_STATUS &&
                          wd[sia_pkg::BIT_TIMER]));                       // see [RULE23]
         soft_sts    <= top_enable[sia_pkg::BIT_SOFT] | (soft_sts &
                        ~(wr_cycle && bus.addr == sia_pkg::ADDR_STATUS &&
                          wd[sia_pkg::BIT_SOFT]));                        // see [RULE24]
         ready_sts   <= first_cycle | events.ready | (ready_sts &
                        ~(wr_cycle && bus.addr == sia_pkg::ADDR_STATUS &&
                          wd[sia_pkg::BIT_READY]));                       // see [RULE25]
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // De-assertion interval: unit prescaler and gap counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         unit_cnt <= '0;
      end else if (gap_cnt == '0 || unit_cnt == 16'(UNIT_CYC - 1)) begin
         unit_cnt <= '0;                                                  // see [RULE27]
      end else begin
         unit_cnt <= unit_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gap_cnt <= '0;
      end else if (irq_active && !next_irq_active) begin
         gap_cnt <= intv;                                                 // see [RULE11] see [RULE10]
      end else if (gap_cnt != '0 && unit_cnt == 16'(UNIT_CYC - 1)) begin
         gap_cnt <= gap_cnt - 1'b1;                                       // see [RULE9]
      end
   end

   assign next_irq_active = any_enabled && irq_cfg[sia_pkg::CFG_IRQ_EN] &&
                            (gap_cnt == '0);                              // see [RULE26] see [RULE7]

   //////////////////////////////////////////////////////////////////////////
   // Pin drive and PHY power-down
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_active    <= 1'b0;
         irq_out       <= 1'b0;
         irq_oe_n      <= 1'b1;
         phy_powerdown <= 2'b00;
      end else begin
         irq_active <= next_irq_active;
         if (irq_cfg[sia_pkg::CFG_PUSH_PULL]) begin
            irq_out  <= next_irq_active ~^ irq_cfg[sia_pkg::CFG_POL_HIGH];  // see [RULE8]
            irq_oe_n <= 1'b0;
         end else begin
            irq_out  <= 1'b0;                                               // see [RULE8]
            irq_oe_n <= ~next_irq_active;
         end
         phy_powerdown[0] <= pd_req[0] | (port_mode != 2'b11);              // see [RULE21]
         phy_powerdown[1] <= pd_req[1];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata <= '0;
      end else if (bus.rd) begin
         unique case (bus.addr)
            sia_pkg::ADDR_STATUS:     rdata <= {6'h00, pd_req, 1'b0, top_status};  // see [RULE6]
            sia_pkg::ADDR_ENABLE:     rdata <= {9'h000, top_enable};
            sia_pkg::ADDR_IRQ_CFG:    rdata <= irq_cfg;
            sia_pkg::ADDR_FAB_PEND:   rdata <= {13'h0000, fab_pend};
            sia_pkg::ADDR_FAB_MASK:   rdata <= {13'h0000, fab_mask};
            sia_pkg::ADDR_BM_PEND:    rdata <= {14'h0000, bm_pend};
            sia_pkg::ADDR_BM_MASK:    rdata <= {14'h0000, bm_mask};
            sia_pkg::ADDR_ENG_PEND:   rdata <= {15'h0000, eng_pend};
            sia_pkg::ADDR_ENG_MASK:   rdata <= {15'h0000, eng_mask};
            sia_pkg::ADDR_PHY1_FLAGS: rdata <= {8'h00, phy_flags[0]};
            sia_pkg::ADDR_PHY1_MASK:  rdata <= {8'h00, phy_mask[0]};
            sia_pkg::ADDR_PHY2_FLAGS: rdata <= {8'h00, phy_flags[1]};
            sia_pkg::ADDR_PHY2_MASK:  rdata <= {8'h00, phy_mask[1]};
            sia_pkg::ADDR_PIN_EVENT:  rdata <= {2'h0, pin_en, 2'h0, pin_pend};
            default:                  rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

endmodule : sia_top

// file: sia_pkg.sv
package sia_pkg;

   // Register indices on the plain register port (word index)
   localparam logic [3:0] ADDR_STATUS     = 4'h0;
   localparam logic [3:0] ADDR_ENABLE     = 4'h1;
   localparam logic [3:0] ADDR_IRQ_CFG    = 4'h2;
   localparam logic [3:0] ADDR_FAB_PEND   = 4'h3;
   localparam logic [3:0] ADDR_FAB_MASK   = 4'h4;
   localparam logic [3:0] ADDR_BM_PEND    = 4'h5;
   localparam logic [3:0] ADDR_BM_MASK    = 4'h6;
   localparam logic [3:0] ADDR_ENG_PEND   = 4'h7;
   localparam logic [3:0] ADDR_ENG_MASK   = 4'h8;
   localparam logic [3:0] ADDR_MAC_PEND   = 4'h9;
   localparam logic [3:0] ADDR_MAC_MASK   = 4'hA;
   localparam logic [3:0] ADDR_PHY1_FLAGS = 4'hB;
   localparam logic [3:0] ADDR_PHY1_MASK  = 4'hC;
   localparam logic [3:0] ADDR_PHY2_FLAGS = 4'hD;
   localparam logic [3:0] ADDR_PHY2_MASK  = 4'hE;
   localparam logic [3:0] ADDR_PIN_EVENT  = 4'hF;

   // Top-level status / enable bit positions
   localparam int BIT_FABRIC = 0;
   localparam int BIT_PHY1   = 1;
   localparam int BIT_PHY2   = 2;
   localparam int BIT_PIN    = 3;
   localparam int BIT_TIMER  = 4;
   localparam int BIT_SOFT   = 5;
   localparam int BIT_READY  = 6;
   localparam int TOP_BITS   = 7;

   // Interrupt configuration fields
   localparam int CFG_IRQ_EN     = 0;
   localparam int CFG_POL_HIGH   = 1;
   localparam int CFG_PUSH_PULL  = 2;
   localparam int CFG_INTV_LSB   = 8;
   localparam int INTV_BITS      = 8;

   // Fabric global pending bit positions
   localparam int FAB_BM  = 0;
   localparam int FAB_ENG = 1;
   localparam int FAB_MAC = 2;

   // PHY event bits; energy present is bit 7
   localparam int PHY_BITS          = 8;
   localparam int ENERGY_EVENT_BIT  = 7;
   localparam logic [7:0] PHY_VALID = 8'hFE;

   localparam int PIN_COUNT = 6;

   // Reset values
   localparam logic [6:0]  RST_ENABLE = 7'h00;
   localparam logic [15:0] RST_CFG    = 16'h0000;

   // De-assertion time unit and its length in clock cycles
   localparam int CLK_HZ       = 25_000_000;
   localparam int UNIT_NS      = 10_000;
   localparam int UNIT_CYCLES  = (UNIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   localparam int CTRL_BITS = 3;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } sia_bus_t;

   typedef struct packed {
      logic [1:0]           bm;
      logic                 eng;
      logic [PIN_COUNT-1:0] pin;
      logic [PHY_BITS-1:0]  phy1;
      logic [PHY_BITS-1:0]  phy2;
      logic                 timer_wrap;
      logic                 ready;
   } sia_events_t;

endpackage : sia_pkg

// file: sia_host_model.sv
`timescale 1ns/10ps
module sia_host_model (
   // Interrupt pin from the device
   input  wire logic irq_out,
   input  wire logic irq_oe_n,
   // Line level seen by the host
   output logic      irq_level
);
   // Shared line with a pull-up: a released pin reads high
   assign irq_level = irq_oe_n ? 1'b1 : irq_out;
endmodule : sia_host_model

// file: sia_properties.sv
`timescale 1ns/10ps
module sia_properties #(
   parameter int INTV_W   = 8,
   parameter int UNIT_CYC = 2
) (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 sys_rst,
   // Register port
   input wire sia_pkg::sia_bus_t    bus,
   input wire logic [15:0]          rdata,
   // Sources and port mode
   input wire sia_pkg::sia_events_t events,
   input wire logic [1:0]           port_mode,
   // Outputs
   input wire logic [1:0]           phy_powerdown,
   input wire logic                 irq_out,
   input wire logic                 irq_oe_n
);
   logic [6:0]  en_sh;
   logic [15:0] cfg_sh;
   logic        act;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   //////////////////////////////////////////////////////////////////////////
   // Shadow copies of the enable and interrupt configuration registers
   always_ff @(posedge clk) begin
      if (sys_rst) en_sh <= sia_pkg::RST_ENABLE;
      else if (bus.wr && bus.addr == sia_pkg::ADDR_ENABLE) en_sh <= bus.wdata[6:0];
   end
   always_ff @(posedge clk) begin
      if (sys_rst) cfg_sh <= sia_pkg::RST_CFG;
      else if (bus.wr && bus.addr == sia_pkg::ADDR_IRQ_CFG) cfg_sh <= bus.wdata;
   end
   assign act = !irq_oe_n && !cfg_sh[2];
   //////////////////////////////////////////////////////////////////////////
   sequence s_fall;
      $fell(act) && !cfg_sh[2] && cfg_sh[15:8] >= 8'h02;
   endsequence
   sequence s_soft;
      (en_sh[5] && cfg_sh[0] && !cfg_sh[2] && cfg_sh[15:8] == 8'h00) [*3];
   endsequence
   chk_mac_zero: assert property (bus.rd && (bus.addr == sia_pkg::ADDR_MAC_PEND ||
      bus.addr == sia_pkg::ADDR_MAC_MASK) |=> rdata == 16'h0000) else $error("reserved MAC reg not zero");
   chk_enable_read: assert property (bus.rd && bus.addr == sia_pkg::ADDR_ENABLE
      |=> rdata[6:0] == $past(en_sh)) else $error("enable readback wrong");
   chk_port_down: assert property (port_mode != 2'h3 |=> phy_powerdown[0])
      else $error("first PHY not powered down");
   chk_irq_gate: assert property (!cfg_sh[0] [*3] |-> irq_oe_n ||
      (cfg_sh[2] && irq_out != cfg_sh[1])) else $error("pin asserted while disabled");
   chk_od_low: assert property (!cfg_sh[2] [*3] |-> !irq_out)
      else $error("open-drain pin drives high");
   chk_min_gap: assert property (s_fall |=> !act [*2])
      else $error("pin reasserted inside interval");
   chk_soft_drive: assert property (s_soft |-> act)
      else $error("soft event not on pin");
   chk_reset_vals: assert property ($fell(sys_rst) |-> rdata == 16'h0000 && irq_oe_n &&
      !irq_out && phy_powerdown == 2'h0) else $error("reset values wrong");
endmodule : sia_properties
bind sia_top sia_properties #(.INTV_W(INTV_W), .UNIT_CYC(UNIT_CYC)) u_props (.clk(clk), .sys_rst(sys_rst),
   .bus(bus), .rdata(rdata), .events(events), .port_mode(port_mode), .phy_powerdown(phy_powerdown),
   .irq_out(irq_out), .irq_oe_n(irq_oe_n));

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
   logic                 clk = 1'b0;
   logic                 sys_rst = 1'b1;
   sia_pkg::sia_bus_t    bus = '0;
   sia_pkg::sia_events_t ev = '0;
   logic [1:0]           port_mode = 2'h3;
   logic [15:0]          rdata;
   logic [1:0]           phy_powerdown;
   logic                 irq_out;
   logic                 irq_oe_n;
   logic                 irq_level;
   int                   n_mismatch = 0;
   int                   checks_done = 0;
   int                   cycles = 0;
   always #20 clk = ~clk;
   sia_top #(.UNIT_CYC(2)) uut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .events(ev),
      .port_mode(port_mode), .phy_powerdown(phy_powerdown), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
   sia_host_model host (.irq_out(irq_out), .irq_oe_n(irq_oe_n), .irq_level(irq_level));
   //////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task wr(input logic [3:0] a, input logic [15:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      cyc(1);
      bus <= '0;
      cyc(1);
   endtask : wr
   task rd(input logic [3:0] a, input logic [15:0] e);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      cyc(1);
      bus <= '0;
      check("rdata", rdata, e);
      cyc(1);
   endtask : rd
   task pulse(input sia_pkg::sia_events_t e);
      ev <= e;
      cyc(1);
      ev <= '0;
      cyc(1);
   endtask : pulse
   task lvl(input logic e);
      check("irq_level", {15'h0, irq_level}, {15'h0, e});
   endtask : lvl
   //////////////////////////////////////////////////////////////////////////
   task t_regs;
      rd(sia_pkg::ADDR_STATUS, 16'h0040);
      wr(sia_pkg::ADDR_STATUS, 16'h0040);
      rd(sia_pkg::ADDR_STATUS, 16'h0000);
      wr(sia_pkg::ADDR_MAC_MASK, 16'hFFFF);
      rd(sia_pkg::ADDR_MAC_MASK, 16'h0000);
      rd(sia_pkg::ADDR_MAC_PEND, 16'h0000);
   endtask : t_regs
   task t_soft;
      logic [15:0] cf [5] = '{16'h0001, 16'h0007, 16'h0005, 16'h0004, 16'h0000};
      logic        ex [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      wr(sia_pkg::ADDR_ENABLE, 16'h0020);
      for (int i = 0; i < 5; i++) begin
         wr(sia_pkg::ADDR_IRQ_CFG, cf[i]);
         cyc(3);
         lvl(ex[i]);
      end
      wr(sia_pkg::ADDR_ENABLE, 16'h0000);
      wr(sia_pkg::ADDR_STATUS, 16'h0020);
      rd(sia_pkg::ADDR_STATUS, 16'h0000);
   endtask : t_soft
   task t_gap;
      sia_pkg::sia_events_t e;
      int n;
      e = '0;
      e.timer_wrap = 1'b1;
      wr(sia_pkg::ADDR_ENABLE, 16'h0010);
      for (int i = 0; i < 2; i++) begin
         wr(sia_pkg::ADDR_IRQ_CFG, i ? 16'h0301 : 16'h0001);
         cyc(8);
         pulse(e);
         cyc(2);
         lvl(1'b0);
         wr(sia_pkg::ADDR_STATUS, 16'h0010);
         n = 0;
         fork
            pulse(e);
            repeat (20) begin
               if (irq_level === 1'b1) n++;
               cyc(1);
            end
         join
         check("gap", {15'h0, i ? (n >= 6 && n <= 9) : (n >= 1 && n <= 3)}, 16'h0001);
      end
      wr(sia_pkg::ADDR_STATUS, 16'h0010);
   endtask : t_gap
   task t_phy;
      sia_pkg::sia_events_t e;
      logic                 lv [2];
      logic [3:0]           fa;
      wr(sia_pkg::ADDR_IRQ_CFG, 16'h0001);
      wr(sia_pkg::ADDR_ENABLE, 16'h0006);
      for (int p = 0; p < 2; p++) begin
         fa = p ? sia_pkg::ADDR_PHY2_FLAGS : sia_pkg::ADDR_PHY1_FLAGS;
         for (int m = 0; m < 2; m++) begin
            wr(fa + 4'h1, m ? 16'h0000 : 16'h00FE);
            e = '0;
            if (p) e.phy2 = 8'hFF;
            else e.phy1 = 8'hFF;
            pulse(e);
            cyc(2);
            lv[m] = irq_level;
            rd(fa, 16'h00FE);
            wr(fa, 16'h00FE);
            rd(fa, 16'h0000);
         end
         check("phy_mask", {15'h0, lv[0] ^ lv[1]}, 16'h0001);
      end
   endtask : t_phy
   task t_tiers;
      sia_pkg::sia_events_t e;
      e = '0;
      e.eng = 1'b1;
      e.bm = 2'h3;
      e.pin = 6'h20;
      wr(sia_pkg::ADDR_ENG_MASK, 16'h0001);
      wr(sia_pkg::ADDR_FAB_MASK, 16'h0002);
      wr(sia_pkg::ADDR_PIN_EVENT, 16'h2000);
      wr(sia_pkg::ADDR_ENABLE, 16'h0009);
      pulse(e);
      cyc(2);
      lvl(1'b0);
      rd(sia_pkg::ADDR_BM_PEND, 16'h0003);
      rd(sia_pkg::ADDR_FAB_PEND, 16'h0002);
      rd(sia_pkg::ADDR_PIN_EVENT, 16'h2020);
      rd(sia_pkg::ADDR_STATUS, 16'h0009);
      wr(sia_pkg::ADDR_ENG_PEND, 16'h0001);
      wr(sia_pkg::ADDR_PIN_EVENT, 16'h2020);
      rd(sia_pkg::ADDR_STATUS, 16'h0000);
      lvl(1'b1);
   endtask : t_tiers
   task t_pd;
      for (int m = 0; m < 4; m++) begin
         port_mode <= m[1:0];
         cyc(3);
         check("pd0", {15'h0, phy_powerdown[0]}, {15'h0, m != 3});
      end
      wr(sia_pkg::ADDR_STATUS, 16'h0200);
      cyc(1);
      check("pd", {14'h0, phy_powerdown}, 16'h0002);
      wr(sia_pkg::ADDR_STATUS, 16'h0000);
      cyc(1);
      check("pd", {14'h0, phy_powerdown}, 16'h0000);
   endtask : t_pd
   //////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(4);
      sys_rst <= 1'b0;
      cyc(1);
      t_regs();
      t_soft();
      t_gap();
      t_phy();
      t_tiers();
      t_pd();
      finish_test();
   end
endmodule : testbench
